// ---- aem_map.svh ----
// Register offsets, field positions, reset values and channel indices for the energy meter.
`ifndef AEM_MAP_SVH
`define AEM_MAP_SVH

`define AEM_STATUS_ADDR   8'h01
`define AEM_ALARM_BASE    8'h05
`define AEM_ALARM_BYTES   8'h05
`define AEM_CFG_ADDR      8'h0F
`define AEM_RES_ADDR      8'h11
`define AEM_SEL_LO_ADDR   8'h13
`define AEM_SEL_HI_ADDR   8'h14
`define AEM_AEN_BASE      8'h16
`define AEM_THR_BASE      8'h1B
`define AEM_THR_BYTES     8'h26
`define AEM_RES_BASE      8'h41
`define AEM_RES_BYTES     8'h06
`define AEM_AUXR_BASE     8'h4A
`define AEM_AUXR_BYTES    8'h20
`define AEM_ENERGY_BASE   8'h7A
`define AEM_ENERGY_BYTES  8'h06
`define AEM_TICK_BASE     8'h80
`define AEM_TICK_BYTES    8'h04
`define AEM_METER_ADDR    8'h84
`define AEM_SNAP_ADDR     8'h85
`define AEM_XSEL_ADDR     8'h86
`define AEM_XRD_BASE      8'h87

`define AEM_CFG_PWR_SEL   0
`define AEM_CFG_CHARGE    1
`define AEM_CFG_MOVF_AEN  2
`define AEM_CFG_TOVF_AEN  3
`define AEM_MC_HALT       0
`define AEM_MC_MOVF       1
`define AEM_MC_TOVF       2
`define AEM_MC_ALERT      3
`define AEM_SNAP_HALT     7

`define AEM_CHANNELS      19
`define AEM_CH_CUR        5'd0
`define AEM_CH_POWER_VOLTAGE_INPUT       5'd1
`define AEM_CH_PWR        5'd2
`define AEM_CH_AUX0       5'd3
`define AEM_DIFF_FIRST    4'd10
`define AEM_RES_MAX       3'd4

`define AEM_SEL_RESET     16'h0001
`define AEM_RES_RESET     3'd2
`define AEM_AUX_IDLE_VAL  16'h0010
`endif

// ---- aem_pkg.sv ----
// Types shared by the energy meter sequencer and its testbench.
package aem_pkg;
   typedef struct packed {
      logic [15:0] current;
      logic [15:0] voltage;
      logic [15:0] aux;
   } aem_sample_type;

   typedef enum logic [1:0] {
      AEM_IDLE = 2'b00,
      AEM_WAIT = 2'b01
   } aem_state_type;
endpackage

// ---- aem_extreme.sv ----
// Min/max tracking and alarm threshold comparison for one measurement.
`timescale 1ns/10ps
module aem_extreme (
   input  wire logic [15:0] value,
   input  wire logic [15:0] min_in,
   input  wire logic [15:0] max_in,
   input  wire logic [7:0]  thr_lo,
   input  wire logic [7:0]  thr_hi,
   output logic      [15:0] min_out,
   output logic      [15:0] max_out,
   output logic             alarm_lo,
   output logic             alarm_hi
);
   // Thresholds are compared with the top byte so they scale with any resolution.
   assign min_out  = (value < min_in) ? value : min_in;
   assign max_out  = (value > max_in) ? value : max_in;
   assign alarm_lo = value[15:8] < thr_lo;
   assign alarm_hi = value[15:8] > thr_hi;
endmodule

// ---- aem_sequencer.sv ----
// Converter sequencing, result registers, alarms and energy metering.
`timescale 1ns/10ps
`include "aem_map.svh"
// Behaviour
// - Five resolutions from 8 to 16 bits.
// - Current converter converts continuously by default.
// - Second converter measures voltage plus selected auxiliary.
// - Several enabled auxiliaries rotate, one per conversion.
// - Status shows channel of latest finished conversion.
// - No auxiliaries: continue, first auxiliary gets small value.
// - Differential auxiliaries lose one bit of resolution.
// - Multiply current by voltage; select bit picks source.
// - New extremes overwrite min and max registers.
// - Results are 16-bit words, left justified.
// - Threshold crossings set alarm log bits.
// - Enabled alarm drives alert low, sets alert flag.
// - Each measurement adds power into 48-bit accumulator.
// - Accumulator overflow sets flag, alert if enabled.
// - Charge mode accumulates current instead of power.
// - Tick counter increments per accumulation.
// - Tick overflow sets flag, alert if enabled.
// - Host may preload accumulator and tick counter.
// - Counter reads use coherent holding buffers.
// - Meter halt freezes both counters until cleared.
// - Snapshot write starts one conversion, clears idle.
// - Snapshot end: halted, idle set, channel shown.
module aem_sequencer (
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   input  wire logic [7:0]              reg_addr,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   input  wire logic [7:0]              reg_wdata,
   output logic      [7:0]              reg_rdata,
   output logic                         conv_start,
   output logic      [2:0]              conv_resolution,
   output logic      [3:0]              conv_aux_channel,
   output logic                         conv_aux_en,
   output logic                         power_source_select,
   input  wire logic                    conv_done,
   input  wire aem_pkg::aem_sample_type conv_sample,
   output logic                         alert_n
);
   aem_pkg::aem_state_type state_q;
   aem_pkg::aem_state_type state_d;
   logic [7:0]  cfg_q;
   logic [2:0]  res_q;
   logic [15:0] sel_q;
   logic [39:0] aen_q;
   logic [39:0] alarm_q;
   logic [39:0] alarm_d;
   logic [39:0] alarm_set;
   logic [7:0]  thr_q [`AEM_THR_BYTES];
   logic [15:0] val_q [`AEM_CHANNELS];
   logic [15:0] min_q [`AEM_CHANNELS];
   logic [15:0] max_q [`AEM_CHANNELS];
   logic [3:0]  meter_q;
   logic [3:0]  meter_d;
   logic [7:0]  snap_q;
   logic [4:0]  xsel_q;
   logic [47:0] energy_q;
   logic [47:0] energy_d;
   logic [47:0] energy_hold_q;
   logic [31:0] tick_q;
   logic [31:0] tick_d;
   logic [31:0] tick_hold_q;
   logic [3:0]  conv_ch_q;
   logic        aux_en_q;
   logic [3:0]  aux_ch_q;
   logic        idle_q;
   logic        snap_pend_q;
   logic [7:0]  rd_mux;
   logic [7:0]  reg_rdata_q;

   function automatic logic [3:0] next_aux(input logic [15:0] mask, input logic [3:0] cur);
      logic [3:0] idx;
      logic [3:0] pick;
      logic       found;
      pick  = cur;
      found = 1'b0;
      for (int i = 1; i <= 16; i++) begin
         idx = cur + 4'(i);
         if (!found && mask[idx]) begin
            pick  = idx;
            found = 1'b1;
         end
      end
      return pick;
   endfunction

   // Address decoding: each window is found by subtracting its base.
   wire [7:0] al_off  = reg_addr - `AEM_ALARM_BASE;
   wire [7:0] aen_off = reg_addr - `AEM_AEN_BASE;
   wire [7:0] th_off  = reg_addr - `AEM_THR_BASE;
   wire [7:0] rs_off  = reg_addr - `AEM_RES_BASE;
   wire [7:0] ax_off  = reg_addr - `AEM_AUXR_BASE;
   wire [7:0] e_off   = reg_addr - `AEM_ENERGY_BASE;
   wire [7:0] t_off   = reg_addr - `AEM_TICK_BASE;
   wire [7:0] x_off   = reg_addr - `AEM_XRD_BASE;
   wire in_alarm  = al_off < `AEM_ALARM_BYTES;
   wire in_aen    = aen_off < `AEM_ALARM_BYTES;
   wire in_thr    = th_off < `AEM_THR_BYTES;
   wire in_res    = rs_off < `AEM_RES_BYTES;
   wire in_auxr   = ax_off < `AEM_AUXR_BYTES;
   wire in_energy = e_off < `AEM_ENERGY_BYTES;
   wire in_tick   = t_off < `AEM_TICK_BYTES;
   wire in_xrd    = x_off < 8'h04;
   wire wr_cfg    = reg_wr && (reg_addr == `AEM_CFG_ADDR);
   wire wr_res    = reg_wr && (reg_addr == `AEM_RES_ADDR);
   wire wr_sel_lo = reg_wr && (reg_addr == `AEM_SEL_LO_ADDR);
   wire wr_sel_hi = reg_wr && (reg_addr == `AEM_SEL_HI_ADDR);
   wire wr_meter  = reg_wr && (reg_addr == `AEM_METER_ADDR);
   wire wr_snap   = reg_wr && (reg_addr == `AEM_SNAP_ADDR);
   wire wr_xsel   = reg_wr && (reg_addr == `AEM_XSEL_ADDR);
   wire wr_alarm  = reg_wr && in_alarm;
   wire wr_aen    = reg_wr && in_aen;
   wire wr_thr    = reg_wr && in_thr;
   wire wr_energy = reg_wr && in_energy;
   wire wr_tick   = reg_wr && in_tick;
   // A snapshot write sets the pending flag on the rising clock edge that takes it,
   // and the start follows from that flag in the next idle cycle.
   wire snap_go   = wr_snap && reg_wdata[`AEM_SNAP_HALT];
   wire snap_halt = snap_q[`AEM_SNAP_HALT];
   wire rd_coh    = reg_rd && ((reg_addr == `AEM_ENERGY_BASE) || (reg_addr == `AEM_TICK_BASE));

   // Sequencer: back to back conversions unless halted, or one pending snapshot.
   wire start = (state_q == aem_pkg::AEM_IDLE) && (snap_pend_q || (!snap_halt && !wr_snap));
   wire store = (state_q == aem_pkg::AEM_WAIT) && conv_done;
   assign conv_start = start;

   always_comb begin
      state_d = state_q;
      case (state_q)
         aem_pkg::AEM_IDLE: begin
            if (start) begin
               state_d = aem_pkg::AEM_WAIT;
            end
         end
         aem_pkg::AEM_WAIT: begin
            if (conv_done) begin
               state_d = aem_pkg::AEM_IDLE;
            end
         end
         default: begin
            state_d = aem_pkg::AEM_IDLE;
         end
      endcase
   end

   // Resolution to left-justify shift; out-of-range codes fall back to full width.
   wire [3:0] res_sh   = (res_q >= `AEM_RES_MAX) ? 4'd0 : 4'd8 - {res_q, 1'b0};
   wire       aux_diff = conv_ch_q >= `AEM_DIFF_FIRST;
   wire [3:0] aux_sh   = aux_diff ? res_sh + 4'd1 : res_sh;
   wire [15:0] cur_lj  = 16'(conv_sample.current << res_sh);
   wire [15:0] vp_lj   = 16'(conv_sample.voltage << res_sh);
   wire [15:0] aux_lj  = 16'(conv_sample.aux << aux_sh);
   wire [31:0] prod    = cur_lj * vp_lj;
   wire [15:0] pwr     = prod[31:16];

   // Four result slots per conversion: current, voltage, power and one auxiliary.
   logic [15:0] upd_val [4];
   logic [4:0]  upd_idx [4];
   logic        upd_en  [4];
   logic [15:0] new_min [4];
   logic [15:0] new_max [4];
   logic        al_lo   [4];
   logic        al_hi   [4];

   assign upd_val[0] = cur_lj;
   assign upd_val[1] = vp_lj;
   assign upd_val[2] = pwr;
   assign upd_val[3] = aux_lj;
   assign upd_idx[0] = `AEM_CH_CUR;
   assign upd_idx[1] = `AEM_CH_POWER_VOLTAGE_INPUT;
   assign upd_idx[2] = `AEM_CH_PWR;
   assign upd_idx[3] = `AEM_CH_AUX0 + {1'b0, conv_ch_q};
   assign upd_en[0]  = 1'b1;
   assign upd_en[1]  = 1'b1;
   assign upd_en[2]  = 1'b1;
   assign upd_en[3]  = aux_en_q;

   for (genvar s = 0; s < 4; s++) begin : g_slot
      aem_extreme u_ext (
         .value   (upd_val[s]),
         .min_in  (min_q[upd_idx[s]]),
         .max_in  (max_q[upd_idx[s]]),
         .thr_lo  (thr_q[{upd_idx[s], 1'b0}]),
         .thr_hi  (thr_q[{upd_idx[s], 1'b1}]),
         .min_out (new_min[s]),
         .max_out (new_max[s]),
         .alarm_lo(al_lo[s]),
         .alarm_hi(al_hi[s])
      );
   end

   always_comb begin
      alarm_set = 40'h00_0000_0000;
      if (store) begin
         for (int s = 0; s < 4; s++) begin
            if (upd_en[s]) begin
               alarm_set[{upd_idx[s], 1'b0}] = al_lo[s];
               alarm_set[{upd_idx[s], 1'b1}] = al_hi[s];
            end
         end
      end
   end

   // Software clears alarm bits by writing zeros; a new alarm in that cycle still sets.
   always_comb begin
      alarm_d = alarm_q;
      if (wr_alarm) begin
         alarm_d[{al_off[2:0], 3'b000} +: 8] = alarm_q[{al_off[2:0], 3'b000} +: 8] & reg_wdata;
      end
      alarm_d = alarm_d | alarm_set;
   end

   // Meter: the host preload of a byte takes priority over an accumulation.
   wire        accumulate = store && !meter_q[`AEM_MC_HALT];
   wire [15:0] acc_add    = cfg_q[`AEM_CFG_CHARGE] ? cur_lj : pwr;
   wire [48:0] energy_sum = {1'b0, energy_q} + {33'h0_0000_0000, acc_add};
   wire [32:0] tick_sum   = {1'b0, tick_q} + 33'h0_0000_0001;
   wire        movf_evt   = accumulate && energy_sum[48];
   wire        tovf_evt   = accumulate && tick_sum[32];
   wire [5:0]  e_pos      = {3'(3'd5 - e_off[2:0]), 3'b000};
   wire [4:0]  t_pos      = {2'(2'd3 - t_off[1:0]), 3'b000};

   always_comb begin
      energy_d = accumulate ? energy_sum[47:0] : energy_q;
      tick_d   = accumulate ? tick_sum[31:0] : tick_q;
      if (wr_energy) begin
         energy_d[e_pos +: 8] = reg_wdata;
      end
      if (wr_tick) begin
         tick_d[t_pos +: 8] = reg_wdata;
      end
   end

   wire alarm_alert = |(alarm_set & aen_q & ~alarm_q);
   wire alert_evt   = alarm_alert || (movf_evt && cfg_q[`AEM_CFG_MOVF_AEN])
                      || (tovf_evt && cfg_q[`AEM_CFG_TOVF_AEN]);

   // Flags clear on a written zero, but an event in the same cycle wins.
   always_comb begin
      meter_d = meter_q;
      if (wr_meter) begin
         meter_d = reg_wdata[3:0] & meter_q;
         meter_d[`AEM_MC_HALT] = reg_wdata[`AEM_MC_HALT];
      end
      meter_d[`AEM_MC_MOVF]  = meter_d[`AEM_MC_MOVF] | movf_evt;
      meter_d[`AEM_MC_TOVF]  = meter_d[`AEM_MC_TOVF] | tovf_evt;
      meter_d[`AEM_MC_ALERT] = meter_d[`AEM_MC_ALERT] | alert_evt;
   end

   assign alert_n = ~meter_q[`AEM_MC_ALERT];

   // Read data for the result, min/max and counter windows.
   wire [4:0]  rch    = in_res ? {3'b000, rs_off[2:1]} : `AEM_CH_AUX0 + {1'b0, ax_off[4:1]};
   wire        rlow   = in_res ? rs_off[0] : ax_off[0];
   wire [15:0] rword  = val_q[rch];
   wire [15:0] xword  = x_off[1] ? max_q[xsel_q] : min_q[xsel_q];
   wire [47:0] e_src  = (reg_addr == `AEM_ENERGY_BASE) ? energy_q : energy_hold_q;
   wire [31:0] t_src  = (reg_addr == `AEM_TICK_BASE) ? tick_q : tick_hold_q;

   always_comb begin
      rd_mux = 8'h00;
      if (reg_addr == `AEM_STATUS_ADDR) begin
         rd_mux = {idle_q, 3'b000, aux_ch_q};
      end else if (in_alarm) begin
         rd_mux = alarm_q[{al_off[2:0], 3'b000} +: 8];
      end else if (reg_addr == `AEM_CFG_ADDR) begin
         rd_mux = cfg_q;
      end else if (reg_addr == `AEM_RES_ADDR) begin
         rd_mux = {5'b00000, res_q};
      end else if (reg_addr == `AEM_SEL_LO_ADDR) begin
         rd_mux = sel_q[7:0];
      end else if (reg_addr == `AEM_SEL_HI_ADDR) begin
         rd_mux = sel_q[15:8];
      end else if (in_aen) begin
         rd_mux = aen_q[{aen_off[2:0], 3'b000} +: 8];
      end else if (in_thr) begin
         rd_mux = thr_q[th_off[5:0]];
      end else if (in_res || in_auxr) begin
         rd_mux = rlow ? rword[7:0] : rword[15:8];
      end else if (in_energy) begin
         rd_mux = e_src[e_pos +: 8];
      end else if (in_tick) begin
         rd_mux = t_src[t_pos +: 8];
      end else if (reg_addr == `AEM_METER_ADDR) begin
         rd_mux = {4'h0, meter_q};
      end else if (reg_addr == `AEM_SNAP_ADDR) begin
         rd_mux = snap_q;
      end else if (reg_addr == `AEM_XSEL_ADDR) begin
         rd_mux = {3'b000, xsel_q};
      end else if (in_xrd) begin
         rd_mux = x_off[0] ? xword[7:0] : xword[15:8];
      end
   end

   assign reg_rdata           = reg_rdata_q;
   assign conv_resolution     = res_q;
   assign conv_aux_channel    = conv_ch_q;
   assign conv_aux_en         = aux_en_q;
   assign power_source_select = cfg_q[`AEM_CFG_PWR_SEL];

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfg_q   <= 8'h00;
         res_q   <= `AEM_RES_RESET;
         sel_q   <= `AEM_SEL_RESET;
         snap_q  <= 8'h00;
         xsel_q  <= 5'd0;
         aen_q   <= 40'h00_0000_0000;
      end else begin
         if (wr_cfg) cfg_q <= reg_wdata;
         if (wr_res) res_q <= reg_wdata[2:0];
         if (wr_sel_lo) sel_q[7:0] <= reg_wdata;
         if (wr_sel_hi) sel_q[15:8] <= reg_wdata;
         if (wr_snap) snap_q <= reg_wdata;
         if (wr_xsel) xsel_q <= reg_wdata[4:0];
         if (wr_aen) aen_q[{aen_off[2:0], 3'b000} +: 8] <= reg_wdata;
      end
   end

   // Low thresholds reset to zero and high ones to full scale, so nothing alarms.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < `AEM_THR_BYTES; i++) begin
            thr_q[i] <= i[0] ? 8'hFF : 8'h00;
         end
      end else if (wr_thr) begin
         thr_q[th_off[5:0]] <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int c = 0; c < `AEM_CHANNELS; c++) begin
            val_q[c] <= 16'h0000;
            min_q[c] <= 16'hFFFF;
            max_q[c] <= 16'h0000;
         end
      end else if (store) begin
         for (int s = 0; s < 4; s++) begin
            if (upd_en[s]) begin
               val_q[upd_idx[s]] <= upd_val[s];
               min_q[upd_idx[s]] <= new_min[s];
               max_q[upd_idx[s]] <= new_max[s];
            end
         end
         if (!aux_en_q) begin
            val_q[`AEM_CH_AUX0] <= `AEM_AUX_IDLE_VAL;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         alarm_q       <= 40'h00_0000_0000;
         meter_q       <= 4'h0;
         energy_q      <= 48'h0000_0000_0000;
         tick_q        <= 32'h0000_0000;
         energy_hold_q <= 48'h0000_0000_0000;
         tick_hold_q   <= 32'h0000_0000;
         reg_rdata_q   <= 8'h00;
      end else begin
         alarm_q  <= alarm_d;
         meter_q  <= meter_d;
         energy_q <= energy_d;
         tick_q   <= tick_d;
         if (rd_coh) begin
            energy_hold_q <= energy_q;
            tick_hold_q   <= tick_q;
         end
         if (reg_rd) reg_rdata_q <= rd_mux;
      end
   end

   // Sequencer state; the next auxiliary is chosen at the end of a conversion
   // so the channel output is settled before the following start.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q     <= aem_pkg::AEM_IDLE;
         conv_ch_q   <= 4'h0;
         aux_en_q    <= 1'b1;
         aux_ch_q    <= 4'h0;
         idle_q      <= 1'b0;
         snap_pend_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (start) snap_pend_q <= 1'b0;
         if (store) begin
            aux_ch_q <= conv_ch_q;
            idle_q   <= snap_halt && !snap_pend_q;
            if (!snap_halt || snap_pend_q) begin
               conv_ch_q <= snap_pend_q ? snap_q[3:0] : next_aux(sel_q, conv_ch_q);
               aux_en_q  <= snap_pend_q || |sel_q;
            end
         end
         if (snap_go && (state_q == aem_pkg::AEM_IDLE || conv_done)) begin
            conv_ch_q   <= reg_wdata[3:0];
            aux_en_q    <= 1'b1;
         end
         if (snap_go) begin
            snap_pend_q <= 1'b1;
            idle_q      <= 1'b0;
         end
      end
   end
endmodule

// ---- aem_monitor.sv ----
// Port checker for the energy meter sequencer.
`timescale 1ns/10ps
module aem_monitor (
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       conv_start,
   input wire logic [3:0] conv_aux_channel,
   input wire logic       conv_aux_en,
   input wire logic       power_source_select,
   input wire logic       conv_done,
   input wire logic       alert_n
);
   logic open_q;
   logic halt_q;
   logic pend_q;
   wire  snap_wr = reg_wr && reg_addr == 8'h85;
   // A snapshot asked for during a running conversion is held pending until its start.
   always_ff @(posedge sys_clk) begin
      open_q <= !rst && (conv_start || (open_q && !conv_done));
      halt_q <= !rst && (snap_wr ? reg_wdata[7] : halt_q);
      pend_q <= !rst && ((snap_wr && reg_wdata[7]) || (pend_q && !conv_start));
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   start_once_a: assert property (conv_start |-> !open_q)
      else $error("conversion started while another is open");
   chan_stable_a: assert property (open_q |-> $stable(conv_aux_channel) && $stable(conv_aux_en))
      else $error("channel changed during a conversion");
   restart_a: assert property (conv_done && open_q && !halt_q ##1 !snap_wr |-> conv_start)
      else $error("continuous mode did not restart");
   snap_stop_a: assert property (conv_done && open_q && halt_q && !pend_q |=> !conv_start)
      else $error("halted converter started again");
   snap_start_a: assert property (snap_wr && reg_wdata[7] |-> ##[1:40] conv_start)
      else $error("snapshot did not start");
   alert_clear_a: assert property (reg_wr && reg_addr == 8'h84 && !reg_wdata[3] && !conv_done
      && !$past(conv_done) |=> alert_n)
      else $error("alert stayed low after clear");
   alert_cause_a: assert property ($fell(alert_n) |-> $past(conv_done) || $past(conv_done, 2))
      else $error("alert without a conversion");
   read_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   src_sel_a: assert property (reg_wr && reg_addr == 8'h0F |=>
      {7'h00, power_source_select} == ($past(reg_wdata) & 8'h01))
      else $error("power source select not taken");
endmodule
bind aem_sequencer aem_monitor u_mon (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .conv_start(conv_start), .conv_aux_channel(conv_aux_channel), .conv_aux_en(conv_aux_en),
   .power_source_select(power_source_select), .conv_done(conv_done), .alert_n(alert_n));

// ---- aem_converter_model.sv ----
// Behavioural converter pair answering the sequencer's conversion requests.
`timescale 1ns/10ps
module aem_converter_model (
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   input  wire logic                    conv_start,
   input  wire logic [2:0]              conv_resolution,
   input  wire logic [3:0]              conv_aux_channel,
   input  wire logic [3:0]              latency,
   input  wire aem_pkg::aem_sample_type raw,
   output logic                         conv_done,
   output aem_pkg::aem_sample_type      conv_sample
);
   logic       busy_q;
   logic [3:0] left_q;
   logic [2:0] res_q;
   logic [3:0] ch_q;
   function automatic logic [15:0] trim(input logic [15:0] v, input int w);
      return v & (16'hFFFF >> (16 - w));
   endfunction
   initial conv_done = 1'b0;
   initial conv_sample = '0;
   // Outside a result the sample lines toggle, so a stale value is never mistaken for data.
   always @(posedge sys_clk) begin
      conv_done <= 1'b0;
      conv_sample <= ~conv_sample;
      if (rst) begin
         busy_q <= 1'b0;
      end else if (conv_start) begin
         busy_q <= 1'b1;
         left_q <= latency;
         res_q <= conv_resolution;
         ch_q <= conv_aux_channel;
      end else if (busy_q && left_q == 4'h0) begin
         busy_q <= 1'b0;
         conv_done <= 1'b1;
         conv_sample <= {trim(raw.current, res_q > 4 ? 16 : 8 + 2 * res_q),
            trim(raw.voltage, res_q > 4 ? 16 : 8 + 2 * res_q),
            trim(raw.aux, (res_q > 4 ? 16 : 8 + 2 * res_q) - (ch_q >= 4'hA ? 1 : 0))};
      end else if (busy_q) begin
         left_q <= left_q - 4'h1;
      end
   end
endmodule

// ---- adc_sequencer_energy_meter_bench.sv ----
// Self-checking bench for the energy meter sequencer.
`timescale 1ns/10ps
`include "aem_map.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
   $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module adc_sequencer_energy_meter_bench;
   logic                    sys_clk = 1'b0;
   logic                    rst = 1'b1;
   logic [7:0]              reg_addr = 8'h00;
   logic [7:0]              reg_wdata = 8'h00;
   logic                    reg_wr = 1'b0;
   logic                    reg_rd = 1'b0;
   logic [7:0]              reg_rdata;
   logic                    conv_start, conv_aux_en, power_source_select, conv_done, alert_n;
   logic [2:0]              conv_resolution;
   logic [3:0]              conv_aux_channel, s0;
   logic [3:0]              latency = 4'h3;
   logic [15:0]             seed = 16'h7727;
   logic [79:0]             v;
   aem_pkg::aem_sample_type raw = '0;
   aem_pkg::aem_sample_type conv_sample;
   int                      bad_count = 0;
   int                      cmp_count = 0;
   always #20 sys_clk = ~sys_clk;
   aem_sequencer dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_start(conv_start),
      .conv_resolution(conv_resolution), .conv_aux_channel(conv_aux_channel),
      .conv_aux_en(conv_aux_en), .power_source_select(power_source_select),
      .conv_done(conv_done), .conv_sample(conv_sample), .alert_n(alert_n));
   aem_converter_model pm (.sys_clk(sys_clk), .rst(rst), .conv_start(conv_start),
      .conv_resolution(conv_resolution), .conv_aux_channel(conv_aux_channel),
      .latency(latency), .raw(raw), .conv_done(conv_done), .conv_sample(conv_sample));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [15:0] lj(input logic [15:0] r, input int res, input int dif);
      int w;
      w = (res > 4 ? 16 : 8 + 2 * res) - dif;
      return (r & (16'hFFFF >> (16 - w))) << (16 - w);
   endfunction
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask
   task automatic fill(input logic [7:0] a, input int n, input logic [7:0] d);
      for (int i = 0; i < n; i++) wr(a + i[7:0], d);
   endtask
   // Bytes land most significant first, so a multi-byte counter reads as one number.
   task automatic rd(input logic [7:0] a, input int n);
      v = '0;
      for (int i = 0; i < n; i++) begin
         @(negedge sys_clk);
         reg_rd = 1'b1;
         reg_addr = a + i[7:0];
         @(negedge sys_clk);
         reg_rd = 1'b0;
         v = {v[71:0], reg_rdata};
      end
   endtask
   task automatic dones(input int n);
      int k;
      k = 0;
      while (n > 0 && k < 3000) begin
         @(negedge sys_clk);
         k++;
         if (conv_done === 1'b1) n--;
      end
      if (n > 0) begin
         bad_count++;
         results();
      end
   endtask
   task automatic snap(input logic [3:0] ch);
      int k;
      k = 0;
      wr(`AEM_SNAP_ADDR, {4'h8, ch});
      v = '0;
      while (v[7] !== 1'b1 && k < 100) begin
         rd(`AEM_STATUS_ADDR, 1);
         k++;
      end
      `CHK("snapshot status", {4'h8, ch}, v[7:0])
   endtask
   initial begin
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
      rd(8'hF0, 1);
      `CHK("unmapped", 8'h00, v[7:0])
      rd(`AEM_SEL_LO_ADDR, 2);
      `CHK("select reset", 16'h0100, v[15:0])
      for (int r = 0; r < 5; r++) begin
         seed = lfsr(seed);
         raw.current = seed;
         seed = lfsr(seed);
         raw.aux = seed;
         latency = seed[3:0] | 4'h1;
         wr(`AEM_RES_ADDR, r[7:0]);
         dones(2);
         rd(`AEM_RES_BASE, 2);
         `CHK("current result", lj(raw.current, r, 0), v[15:0])
         rd(`AEM_AUXR_BASE, 2);
         `CHK("aux0 result", lj(raw.aux, r, 0), v[15:0])
      end
      latency = 4'h8;
      wr(`AEM_SEL_LO_ADDR, 8'h06);
      dones(2);
      rd(`AEM_STATUS_ADDR, 1);
      s0 = v[3:0];
      `CHK("first channel", 1'b1, s0 == 4'h1 || s0 == 4'h2)
      dones(1);
      rd(`AEM_STATUS_ADDR, 1);
      `CHK("rotation", s0 ^ 4'h3, v[3:0])
      wr(`AEM_SEL_LO_ADDR, 8'h00);
      dones(2);
      rd(`AEM_AUXR_BASE, 2);
      `CHK("no aux value", `AEM_AUX_IDLE_VAL, v[15:0])
      raw.current = seed | 16'h8000;
      raw.voltage = lfsr(seed) | 16'h8000;
      wr(`AEM_CFG_ADDR, 8'h02);
      snap(4'hA);
      rd(`AEM_AUXR_BASE + 8'h14, 2);
      `CHK("differential aux", lj(raw.aux, 4, 1), v[15:0])
      wr(`AEM_XSEL_ADDR, 8'h0D);
      rd(`AEM_XRD_BASE, 4);
      `CHK("aux extremes", {2{lj(raw.aux, 4, 1)}}, v[31:0])
      fill(`AEM_ENERGY_BASE, 10, 8'h00);
      snap(4'h0);
      rd(`AEM_ENERGY_BASE, 10);
      `CHK("charge meter", {32'h0, raw.current, 32'h1}, v)
      wr(`AEM_CFG_ADDR, 8'h01);
      snap(4'h0);
      rd(`AEM_RES_BASE + 8'h04, 2);
      `CHK("power", 32'(raw.current) * raw.voltage >> 16, 32'(v[15:0]))
      rd(`AEM_ENERGY_BASE, 10);
      `CHK("energy", 48'(raw.current) + (48'(raw.current) * raw.voltage >> 16), v[79:32])
      `CHK("ticks", 32'h2, v[31:0])
      wr(`AEM_METER_ADDR, 8'h01);
      snap(4'h0);
      rd(`AEM_TICK_BASE, 4);
      `CHK("halted ticks", 32'h2, v[31:0])
      wr(`AEM_METER_ADDR, 8'h00);
      wr(`AEM_CFG_ADDR, 8'h08);
      fill(`AEM_TICK_BASE, 4, 8'hFF);
      snap(4'h0);
      rd(`AEM_METER_ADDR, 1);
      `CHK("tick overflow", 8'h0C, v[7:0])
      `CHK("alert low", 1'b0, alert_n)
      wr(`AEM_METER_ADDR, 8'h00);
      wr(`AEM_CFG_ADDR, 8'h00);
      fill(`AEM_ENERGY_BASE, 6, 8'hFF);
      snap(4'h0);
      rd(`AEM_METER_ADDR, 1);
      `CHK("meter overflow", 8'h02, v[7:0])
      `CHK("no alert", 1'b1, alert_n)
      wr(`AEM_THR_BASE + 8'h01, 8'h00);
      wr(`AEM_AEN_BASE, 8'h02);
      snap(4'h0);
      rd(`AEM_ALARM_BASE, 1);
      `CHK("alarm bit", 8'h02, v[7:0] & 8'h02)
      `CHK("alarm alert", 1'b0, alert_n)
      wr(`AEM_SNAP_ADDR, 8'h00);
      dones(2);
      results();
   end
endmodule
